// ---- alrw_regs.vh ----
// Purpose: Register offsets, entry field positions, reset values and timing counts
// Assumes: Included by bare name from the manual entry write data bank files
// Notes: Offsets are register numbers on the plain register port, not byte addresses
`ifndef ALRW_REGS_VH
`define ALRW_REGS_VH

// Register numbers
`define ALRW_ADDR_CMD 16'h1800
`define ALRW_ADDR_WR_LOW 16'h1801
`define ALRW_ADDR_WR_HIGH 16'h1802
`define ALRW_ADDR_STATUS 16'h1810
`define ALRW_ADDR_CONFIG 16'h1811

// Table command register
`define ALRW_CMD_MAKE_BIT 2

// High write data register fields
`define ALRW_HI_VALID_BIT 24
`define ALRW_HI_AGE_BIT 23
`define ALRW_HI_STATIC_BIT 22
`define ALRW_HI_FILTER_BIT 21
`define ALRW_HI_USED_MSB 24
`define ALRW_HI_MAC_MSB 15

// Reset values
`define ALRW_RESET_LOW 32'h00000000
`define ALRW_RESET_HIGH 25'h0000000
`define ALRW_RESERVED_READ 7'h00

// Status and global config bits
`define ALRW_STS_PENDING_BIT 0
`define ALRW_STS_FULL_BIT 1
`define ALRW_CFG_PRIO_EN_BIT 5

// Stored entry: {high[24:0], low[31:0]}
`define ALRW_ENT_W 57
`define ALRW_ENT_VALID 56
`define ALRW_ENT_AGE 55
`define ALRW_ENT_STATIC 54
`define ALRW_ENT_FILTER 53
`define ALRW_ENT_PRIO_HI 52
`define ALRW_ENT_PRIO_LO 51
`define ALRW_ENT_PORT_HI 50
`define ALRW_ENT_PORT_LO 48
`define ALRW_ENT_MAC_HI 47

// Table size
`define ALRW_TBL_DEPTH 8

// Aging: one sweep per period, so an idle entry with age set goes in one to two periods, one with age clear within one
`define ALRW_CLK_PERIOD_NS 64'd8
`define ALRW_AGE_PERIOD_S 64'd300
// 300 s of 8 ns cycles, sized to the divider so no bits are dropped
`define ALRW_AGE_CYCLES 40'd37500000000
`define ALRW_AGE_CNT_W 40

`endif

// ---- alrw_age_tick.v ----
// Purpose: Free running divider giving one aging pulse per aging period
// Assumes: Single clock, synchronous active-low reset
// Notes: Period is a parameter so a simulation can shorten it
`include "alrw_regs.vh"

module alrw_age_tick #(
    parameter [`ALRW_AGE_CNT_W-1:0] TICK_CYCLES = `ALRW_AGE_CYCLES
) (
    input wire sys_clk,
    input wire rst_b,
    output reg tick_q
);

    reg [`ALRW_AGE_CNT_W-1:0] cnt_q;

    // Count to the period and emit a single-cycle pulse
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            cnt_q <= {`ALRW_AGE_CNT_W{1'b0}};
            tick_q <= 1'b0;
        end else if (cnt_q >= TICK_CYCLES - 1'b1) begin
            cnt_q <= {`ALRW_AGE_CNT_W{1'b0}};
            tick_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

endmodule // alrw_age_tick

// ---- alrw_entry_bank.v ----
// Purpose: Staging registers for a manual table entry, the make command and a small table
// Assumes: Plain register port, read data one cycle after the read strobe
// Notes: Learn, aging and lookup inputs come from logic on the same clock
//
// The implementer's own choice: strobed register access.
`include "alrw_regs.vh"

module alrw_entry_bank #(
    parameter [`ALRW_AGE_CNT_W-1:0] AGE_CYCLES = `ALRW_AGE_CYCLES
) (
    input wire sys_clk,
    input wire rst_b,
    input wire [15:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_q,
    input wire sa_valid,
    input wire [47:0] sa_mac,
    input wire [1:0] sa_port,
    input wire da_valid,
    input wire [47:0] da_mac,
    output reg da_done_q,
    output reg da_hit_q,
    output reg da_drop_q,
    output reg da_override_q,
    output reg da_prio_use_q,
    output reg [1:0] da_prio_q,
    output reg [2:0] da_portmap_q
);

    localparam ST_IDLE = 1'b0;
    localparam ST_MAKE = 1'b1;
    localparam N = `ALRW_TBL_DEPTH;
    localparam W = `ALRW_ENT_W;

    reg [31:0] low_q;
    reg [`ALRW_HI_USED_MSB:0] high_q;
    reg cmd_make_q;
    reg state_q;
    reg full_q;
    reg prio_en_q;

    wire age_tick;
    wire [W*N-1:0] ent_flat;
    wire [N-1:0] make_hit;
    wire [N-1:0] sa_hit;
    wire [N-1:0] da_hit;
    wire [N-1:0] free;
    wire [47:0] staged_mac;
    wire [W-1:0] make_word;
    wire make_trig;
    wire make_valid;

    reg [N-1:0] make_sel;
    reg [N-1:0] learn_sel;
    reg [W-1:0] sa_ent;
    reg [W-1:0] da_ent;
    reg make_any;
    reg free_any;
    reg sa_any;
    reg da_any;
    reg make_go;
    reg learn_go;
    reg [W-1:0] learn_word;
    reg [31:0] rdata_d;
    integer i;
    integer j;
    integer k;

    // Port field decode into a map of port 0, 1, 2: codes 0 to 2 one-hot, codes 4 to 7 several ports
    function [2:0] port_decode;
        input [2:0] code;
        begin
            case (code)
                3'h0: port_decode = 3'h1;
                3'h1: port_decode = 3'h2;
                3'h2: port_decode = 3'h4;
                3'h4: port_decode = 3'h3;
                3'h5: port_decode = 3'h5;
                3'h6: port_decode = 3'h6;
                3'h7: port_decode = 3'h7;
                default: port_decode = 3'h0; // Reserved code forwards nowhere
            endcase
        end
    endfunction

    alrw_age_tick #(
        .TICK_CYCLES(AGE_CYCLES)
    ) u_age_tick (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .tick_q(age_tick)
    );

    // MAC as staged: low word first on the wire, high half last
    assign staged_mac = {high_q[`ALRW_HI_MAC_MSB:0], low_q};
    assign make_word = {high_q, low_q};
    assign make_valid = high_q[`ALRW_HI_VALID_BIT];
    // Only the 0 to 1 transition of the make bit starts a command
    assign make_trig = reg_wr && (reg_addr == `ALRW_ADDR_CMD) &&
        reg_wdata[`ALRW_CMD_MAKE_BIT] && !cmd_make_q;

    // Staging registers; nothing here touches the table
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            low_q <= `ALRW_RESET_LOW;
            high_q <= `ALRW_RESET_HIGH;
        end else if (reg_wr) begin
            if (reg_addr == `ALRW_ADDR_WR_LOW) begin
                low_q <= reg_wdata;
            end
            if (reg_addr == `ALRW_ADDR_WR_HIGH) begin
                high_q <= reg_wdata[`ALRW_HI_USED_MSB:0];
            end
        end
    end

    // Command bit and global priority enable are plain software storage
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            cmd_make_q <= 1'b0;
            prio_en_q <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == `ALRW_ADDR_CMD) begin
                cmd_make_q <= reg_wdata[`ALRW_CMD_MAKE_BIT];
            end
            if (reg_addr == `ALRW_ADDR_CONFIG) begin
                prio_en_q <= reg_wdata[`ALRW_CFG_PRIO_EN_BIT];
            end
        end
    end

    // Make sequencer: latch the trigger, then look up and commit in the next cycle
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
            full_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (make_trig) begin
                        state_q <= ST_MAKE;
                    end
                end
                ST_MAKE: begin
                    state_q <= ST_IDLE;
                    full_q <= make_valid && !make_any && !free_any;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Per-entry storage and matchers
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : g_ent
            reg [W-1:0] ent_q;
            wire vld;
            assign vld = ent_q[`ALRW_ENT_VALID];
            assign make_hit[g] = vld && (ent_q[`ALRW_ENT_MAC_HI:0] == staged_mac);
            assign sa_hit[g] = vld && (ent_q[`ALRW_ENT_MAC_HI:0] == sa_mac);
            assign da_hit[g] = vld && (ent_q[`ALRW_ENT_MAC_HI:0] == da_mac);
            assign free[g] = !vld;
            assign ent_flat[g*W +: W] = ent_q;

            // Make beats learning, learning beats aging in a shared cycle
            always @(posedge sys_clk) begin
                if (!rst_b) begin
                    ent_q <= {W{1'b0}};
                end else if (make_go && make_sel[g]) begin
                    ent_q <= make_word;
                end else if (learn_go && learn_sel[g]) begin
                    ent_q <= learn_word;
                end else if (age_tick && vld && !ent_q[`ALRW_ENT_STATIC]) begin
                    // A sweep clears a set age bit, else removes: 1 to 2 periods idle with age set, up to 1 with it clear
                    if (ent_q[`ALRW_ENT_AGE]) begin
                        ent_q[`ALRW_ENT_AGE] <= 1'b0;
                    end else begin
                        ent_q[`ALRW_ENT_VALID] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Slot choice for a make: the entry with the same MAC, else the first free
    always @* begin
        make_sel = {N{1'b0}};
        make_any = 1'b0;
        free_any = 1'b0;
        for (i = 0; i < N; i = i + 1) begin
            if (make_hit[i] && !make_any) begin
                make_sel = {N{1'b0}};
                make_sel[i] = 1'b1;
                make_any = 1'b1;
            end
        end
        for (i = N - 1; i >= 0; i = i - 1) begin
            if (free[i] && !make_any) begin
                make_sel = {N{1'b0}};
                make_sel[i] = 1'b1;
                free_any = 1'b1;
            end
        end
        // An invalidate with no matching MAC must not take a free slot
        make_go = (state_q == ST_MAKE) && (make_any || (make_valid && free_any));
    end

    // Source lookup and learning word
    always @* begin
        sa_ent = {W{1'b0}};
        sa_any = 1'b0;
        learn_sel = {N{1'b0}};
        for (j = 0; j < N; j = j + 1) begin
            if (sa_hit[j] && !sa_any) begin
                sa_ent = ent_flat[j*W +: W];
                learn_sel[j] = 1'b1;
                sa_any = 1'b1;
            end
        end
        if (!sa_any) begin
            for (j = N - 1; j >= 0; j = j - 1) begin
                if (free[j]) begin
                    learn_sel = {N{1'b0}};
                    learn_sel[j] = 1'b1;
                end
            end
        end
        // Known MAC keeps filter and priority; a new one starts plain
        learn_word = {1'b1, 1'b1, 1'b0, sa_ent[`ALRW_ENT_FILTER],
            sa_ent[`ALRW_ENT_PRIO_HI:`ALRW_ENT_PRIO_LO], 1'b0, sa_port, sa_mac};
        if (!sa_any) begin
            learn_word[`ALRW_ENT_FILTER:`ALRW_ENT_PRIO_LO] = 3'h0;
        end
        // Static entries are left exactly as software made them
        learn_go = sa_valid && (|learn_sel) && !(sa_any && sa_ent[`ALRW_ENT_STATIC]);
    end

    // Destination lookup entry select
    always @* begin
        da_ent = {W{1'b0}};
        da_any = 1'b0;
        for (k = 0; k < N; k = k + 1) begin
            if (da_hit[k] && !da_any) begin
                da_ent = ent_flat[k*W +: W];
                da_any = 1'b1;
            end
        end
    end

    // Forwarding decision, registered one cycle after the request
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            da_done_q <= 1'b0;
            da_hit_q <= 1'b0;
            da_drop_q <= 1'b0;
            da_override_q <= 1'b0;
            da_prio_use_q <= 1'b0;
            da_prio_q <= 2'h0;
            da_portmap_q <= 3'h0;
        end else begin
            da_done_q <= da_valid;
            da_hit_q <= da_valid && da_any;
            da_drop_q <= da_valid && da_any && da_ent[`ALRW_ENT_FILTER];
            da_override_q <= da_valid && da_any && da_ent[`ALRW_ENT_STATIC] &&
                da_ent[`ALRW_ENT_AGE];
            da_prio_use_q <= da_valid && da_any && da_ent[`ALRW_ENT_STATIC] &&
                prio_en_q;
            // Gated so a lingering lookup address cannot leak a priority
            da_prio_q <= (da_valid && da_any) ?
                da_ent[`ALRW_ENT_PRIO_HI:`ALRW_ENT_PRIO_LO] : 2'h0;
            da_portmap_q <= (da_valid && da_any) ?
                port_decode(da_ent[`ALRW_ENT_PORT_HI:`ALRW_ENT_PORT_LO]) : 3'h0;
        end
    end

    // Read decode; unmapped numbers read zero
    always @* begin
        rdata_d = 32'h00000000;
        case (reg_addr)
            `ALRW_ADDR_CMD: begin
                rdata_d[`ALRW_CMD_MAKE_BIT] = cmd_make_q;
            end
            `ALRW_ADDR_WR_LOW: begin
                rdata_d = low_q;
            end
            `ALRW_ADDR_WR_HIGH: begin
                rdata_d = {`ALRW_RESERVED_READ, high_q};
            end
            `ALRW_ADDR_STATUS: begin
                rdata_d[`ALRW_STS_PENDING_BIT] = (state_q == ST_MAKE) || make_trig;
                rdata_d[`ALRW_STS_FULL_BIT] = full_q;
            end
            `ALRW_ADDR_CONFIG: begin
                rdata_d[`ALRW_CFG_PRIO_EN_BIT] = prio_en_q;
            end
            default: begin
                rdata_d = 32'h00000000;
            end
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            reg_rdata_q <= 32'h00000000;
        end else if (reg_rd) begin
            reg_rdata_q <= rdata_d;
        end else begin
            reg_rdata_q <= 32'h00000000;
        end
    end

endmodule // alrw_entry_bank

// ---- alrw_chk_assertions.sv ----
// Purpose: Port-level checks for the manual entry bank
// Assumes: One clock, synchronous active-low reset
// Notes: Read data is checked in the cycle after its strobe and must be zero in every other cycle
`include "alrw_regs.vh"
module alrw_chk #(
    parameter [`ALRW_AGE_CNT_W-1:0] AGE_CYCLES = `ALRW_AGE_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [15:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata_q,
    input wire logic da_valid,
    input wire logic da_done_q,
    input wire logic da_hit_q,
    input wire logic da_drop_q,
    input wire logic da_override_q,
    input wire logic da_prio_use_q,
    input wire logic [1:0] da_prio_q,
    input wire logic [2:0] da_portmap_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    // Decoded accesses; known lists every mapped register number
    wire wlo = reg_wr && reg_addr == `ALRW_ADDR_WR_LOW;
    wire rlo = reg_rd && reg_addr == `ALRW_ADDR_WR_LOW;
    wire whi = reg_wr && reg_addr == `ALRW_ADDR_WR_HIGH;
    wire rhi = reg_rd && reg_addr == `ALRW_ADDR_WR_HIGH;
    wire known = reg_addr == `ALRW_ADDR_CMD || reg_addr == `ALRW_ADDR_WR_LOW ||
        reg_addr == `ALRW_ADDR_WR_HIGH || reg_addr == `ALRW_ADDR_STATUS ||
        reg_addr == `ALRW_ADDR_CONFIG;
    wire [8:0] outs = {da_hit_q, da_drop_q, da_override_q, da_prio_use_q, da_prio_q,
        da_portmap_q};

    // Write, idle cycle, then the read of the same place
    sequence s_next_rd(r);
        !reg_wr ##1 r;
    endsequence
    // No low staging write for two cycles, then a read of the low register
    sequence s_hold;
        (!wlo) [*2] ##1 rlo;
    endsequence
    // Masked write data comes back on the read
    property p_back(w, r, logic [31:0] m);
        logic [31:0] v;
        (w, v = reg_wdata & m) ##1 s_next_rd(r) |=> reg_rdata_q == v;
    endproperty
    // A make between two reads leaves the staged value as it was
    property p_hold;
        logic [31:0] v;
        rlo ##1 (!wlo, v = reg_rdata_q) ##1 s_hold |=> reg_rdata_q == v;
    endproperty

    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h0)
        else $error("read data not zero outside its slot");
    AST_LOW_BACK: assert property (p_back(wlo, rlo, 32'hffffffff))
        else $error("low staging read back wrong");
    AST_HIGH_BACK: assert property (p_back(whi, rhi, 32'h01ffffff))
        else $error("high staging read back wrong");
    AST_HIGH_RSVD: assert property ($past(rhi) |-> reg_rdata_q[31:25] == 7'h00)
        else $error("reserved high bits not zero");
    AST_UNMAPPED: assert property ($past(reg_rd && !known) |-> reg_rdata_q == 32'h0)
        else $error("unmapped read not zero");
    AST_DA_ONE: assert property (da_valid |=> da_done_q)
        else $error("lookup answer missing");
    AST_DA_QUIET: assert property (!da_done_q |-> outs == 9'h000)
        else $error("lookup result outside its slot");
    AST_NEED_HIT: assert property (da_done_q && !da_hit_q |-> outs[7:0] == 8'h00)
        else $error("miss carries result bits");
    AST_STAGE_HOLD: assert property (p_hold)
        else $error("staging changed by make");
endmodule // alrw_chk

bind alrw_entry_bank alrw_chk #(.AGE_CYCLES(AGE_CYCLES)) alrw_chk_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .da_valid(da_valid),
    .da_done_q(da_done_q), .da_hit_q(da_hit_q), .da_drop_q(da_drop_q),
    .da_override_q(da_override_q), .da_prio_use_q(da_prio_use_q), .da_prio_q(da_prio_q),
    .da_portmap_q(da_portmap_q));

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the manual entry bank
// Assumes: Aging period cut to 20 cycles so idle entries leave quickly
// Notes: Seeded random fields plus every port code and removals
`include "alrw_regs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [39:0] AGE = 40'd20;
    localparam [15:0] LO = `ALRW_ADDR_WR_LOW;
    localparam [15:0] HI = `ALRW_ADDR_WR_HIGH;
    // Port map per code, code 0 lowest; reserved code maps to nothing
    localparam [23:0] MAP = {3'h7, 3'h6, 3'h5, 3'h3, 3'h0, 3'h4, 3'h2, 3'h1};
    logic sys_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic sa_valid = 1'b0, da_valid = 1'b0, en;
    logic [15:0] reg_addr = 16'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata_q, d, q;
    logic [47:0] sa_mac = 48'h0, da_mac = 48'h0, nm;
    logic [1:0] sa_port = 2'h0, da_prio_q;
    logic [2:0] da_portmap_q;
    logic da_done_q, da_hit_q, da_drop_q, da_override_q, da_prio_use_q;
    logic [47:0] macs [8];
    logic [24:0] hs [8];
    int n_mismatch = 0;
    int samples_checked = 0;
    int i;

    // 125 MHz clock
    always #4 sys_clk = ~sys_clk;

    alrw_entry_bank #(.AGE_CYCLES(AGE)) alrw_entry_bank_inst (
        .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .sa_valid(sa_valid),
        .sa_mac(sa_mac), .sa_port(sa_port), .da_valid(da_valid), .da_mac(da_mac),
        .da_done_q(da_done_q), .da_hit_q(da_hit_q), .da_drop_q(da_drop_q),
        .da_override_q(da_override_q), .da_prio_use_q(da_prio_use_q), .da_prio_q(da_prio_q),
        .da_portmap_q(da_portmap_q));

    // Lookup result: done, hit, drop, override, prio use, prio, port map
    function automatic logic [9:0] want(input logic [24:0] h, input logic e);
        if (h[24] !== 1'b1)
            return 10'h200;
        return {2'b11, h[21], h[22] & h[23], h[22] & e, h[20:19], MAP[3 * h[18:16] +: 3]};
    endfunction

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Bus tasks start just after an edge and leave one idle cycle behind
    task automatic wr(input logic [15:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [15:0] a, output logic [31:0] v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata_q;
        @(posedge sys_clk);
    endtask

    task automatic look(input logic [47:0] m, input logic [9:0] e);
        da_mac <= m;
        da_valid <= 1'b1;
        @(posedge sys_clk);
        da_valid <= 1'b0;
        #1 chk({da_done_q, da_hit_q, da_drop_q, da_override_q, da_prio_use_q, da_prio_q,
            da_portmap_q}, e);
        @(posedge sys_clk);
    endtask

    task automatic learn(input logic [47:0] m, input logic [1:0] p);
        sa_mac <= m;
        sa_port <= p;
        sa_valid <= 1'b1;
        @(posedge sys_clk);
        sa_valid <= 1'b0;
        @(posedge sys_clk);
    endtask

    // Reserved high bits written as ones to show they are dropped
    task automatic stage(input logic [47:0] m, input logic [24:0] h);
        wr(LO, m[31:0]);
        wr(HI, {7'h7f, h});
    endtask

    // Make, check staging survives, poll pending with a bound, drop the bit
    task automatic make(input logic [31:0] lo, input logic f);
        int k;
        rd(LO, q);
        wr(`ALRW_ADDR_CMD, 32'h4);
        rd(LO, q);
        chk(q, lo);
        for (k = 0; k < 8; k++) begin
            rd(`ALRW_ADDR_STATUS, q);
            if (q[0] === 1'b0)
                break;
        end
        if (k == 8) begin
            n_mismatch++;
            results();
        end
        chk(q[1:0], {f, 1'b0});
        wr(`ALRW_ADDR_CMD, 32'h0);
    endtask

    task automatic results();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Main sequence
    initial begin
        q = $urandom(26);
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        rd(LO, q);
        chk(q, 32'h0);
        rd(HI, q);
        chk(q, 32'h0);
        for (i = 0; i < 8; i++) begin
            d = $urandom();
            wr(LO, d);
            rd(LO, q);
            chk(q, d);
            d = $urandom();
            wr(HI, d);
            rd(HI, q);
            chk(q, {7'h00, d[24:0]});
        end
        wr(16'h1803, 32'hffffffff);
        rd(16'h1803, q);
        chk(q, 32'h0);
        rd(HI, q);
        chk(q, {7'h00, d[24:0]});
        // Every port code; first half static, priority enable toggling
        for (i = 0; i < 8; i++) begin
            en = i[0];
            d = $urandom();
            macs[i] = {d[15:0], $urandom()};
            hs[i] = {1'b1, i[2] | d[23], ~i[2], d[21:19], i[2:0], macs[i][47:32]};
            wr(`ALRW_ADDR_CONFIG, {26'h0, en, 5'h0});
            stage(macs[i], hs[i]);
            look(macs[i], 10'h200);
            make(macs[i][31:0], 1'b0);
            look(macs[i], want(hs[i], en));
        end
        // Idle dynamic entries age out, static ones stay
        repeat (50) @(posedge sys_clk);
        wr(`ALRW_ADDR_CONFIG, 32'h20);
        for (i = 0; i < 8; i++)
            look(macs[i], i < 4 ? want(hs[i], 1'b1) : 10'h200);
        learn(macs[0], 2'h2);
        look(macs[0], want(hs[0], 1'b1));
        q = $urandom();
        nm = {q[15:0], $urandom()};
        learn(nm, 2'h1);
        look(nm, want({9'h181, nm[47:32]}, 1'b1));
        // Source traffic keeps a dynamic entry alive past two periods
        for (i = 0; i < 6; i++) begin
            learn(nm, 2'h1);
            repeat (8) @(posedge sys_clk);
        end
        look(nm, want({9'h181, nm[47:32]}, 1'b1));
        repeat (50) @(posedge sys_clk);
        look(nm, 10'h200);
        // Commit with valid and static clear removes the static entries
        for (i = 0; i < 4; i++) begin
            stage(macs[i], {9'h000, macs[i][47:32]});
            make(macs[i][31:0], 1'b0);
            look(macs[i], 10'h200);
        end
        // Eight static entries fill the table; a ninth is refused and flagged full
        for (i = 0; i < 9; i++) begin
            nm = {16'h0a00, 24'h0, i[7:0]};
            stage(nm, {9'h140, nm[47:32]});
            make(nm[31:0], i == 8);
        end
        look(nm, 10'h200);
        look({16'h0a00, 32'h0}, want({9'h140, 16'h0a00}, 1'b1));
        // Invalidating an absent address writes nothing and clears the full flag
        stage(nm, {9'h000, nm[47:32]});
        make(nm[31:0], 1'b0);
        look({16'h0a00, 32'h1}, want({9'h140, 16'h0a00}, 1'b1));
        results();
    end
endmodule // tb_top
